// ### verilog/ppi_pkg.sv
// Purpose: shared constants for the port pin interrupt unit
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: all offsets are byte addresses
`default_nettype none
package ppi_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;   // sticky pin events, read clears
    localparam logic [7:0] OFS_MASK = 8'h04;     // interrupt mask
    localparam logic [7:0] OFS_MODE = 8'h08;     // two mode bits per pin
    localparam logic [7:0] OFS_INCFG = 8'h0c;    // threshold and buffer disables
    localparam logic [7:0] OFS_SIOCFG = 8'h10;   // special pin settings
    localparam logic [7:0] OFS_PINS = 8'h14;     // synchronised pin levels
    // edge modes
    typedef enum logic [1:0]
    {
        PPI_EDGE_NONE = 2'b00,
        PPI_EDGE_RISE = 2'b01,
        PPI_EDGE_FALL = 2'b10,
        PPI_EDGE_BOTH = 2'b11
    } ppi_edge_t;
    // input threshold references
    typedef enum logic [1:0]
    {
        PPI_TH_HALF_VDDIO = 2'b00,
        PPI_TH_040_VDDIO = 2'b01,
        PPI_TH_HALF_VREF = 2'b10,
        PPI_TH_VREF = 2'b11
    } ppi_thresh_t;
    // field positions in the input configuration register
    localparam int INCFG_LVTTL_BIT = 0;
    localparam int INCFG_DIS_LSB = 8;
    // field positions in the special pin register
    localparam int SIO_REG_LSB = 0;      // regulated-output select, 2 bits
    localparam int SIO_TH_LSB = 8;       // pair threshold, 2 bits
    // ahb constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ### verilog/ppi_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: pins are asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ppi_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by the second stage
    // two stages in series
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### verilog/ppi_edge.sv
// Purpose: per-pin edge detector with selectable edge mode
// Assumes: input already synchronised to clk
// Notes: edge only, there is no level mode
`timescale 1ns/1ps
`default_nettype none
module ppi_edge #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pin levels and per-pin modes
    input wire logic [WIDTH-1:0] level,
    input wire logic [2*WIDTH-1:0] mode,
    // one-cycle event per pin
    output logic [WIDTH-1:0] event_p
);
    logic [WIDTH-1:0] prev_reg; // level one cycle ago
    // remember previous level to see transitions
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prev_reg <= '0;
        else
            prev_reg <= level;
    end
    // one decoder per pin
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            logic rise;
            logic fall;
            assign rise = level[i] & ~prev_reg[i];
            assign fall = ~level[i] & prev_reg[i];
            always_comb
            begin
                case (ppi_pkg::ppi_edge_t'(mode[2*i +: 2]))
                    ppi_pkg::PPI_EDGE_RISE: event_p[i] = rise;
                    ppi_pkg::PPI_EDGE_FALL: event_p[i] = fall;
                    ppi_pkg::PPI_EDGE_BOTH: event_p[i] = rise | fall;
                    default: event_p[i] = 1'b0;
                endcase
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/ppi_port_irq.sv
// Purpose: pin interrupt unit and input configuration for one 8-pin port
// Assumes: one instance per port, clk keeps running in sleep modes
// Notes: registers on AHB-Lite, zero wait states, always OKAY
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) per-pin rising, falling, both or no edge
// (R2) eight pins grouped into one unit
// (R3) unit drives its own interrupt line
// (R4) matching edge sets status bit, raises request
// (R5) detection runs whenever clk runs, sleep too
// (R6) edge detection only, no level mode
// (R7) one CMOS or LVTTL threshold per port
// (R8) per-pin input buffer disable, drive independent
// (R9) special pin regulated output blocks resistive pulls
// (R10) pin pair shares reference, four thresholds
// (R11) status read clears bits, request drops
module ppi_port_irq #(
    parameter int PINS = 8,
    parameter int SIO_PAIRS = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // port pins
    input wire logic [PINS-1:0] pin_in,
    // interrupt toward the interrupt controller
    output logic port_irq,
    // input buffer controls
    output logic lvttl_sel,
    output logic [PINS-1:0] inbuf_dis,
    // special pin controls
    output logic [2*SIO_PAIRS-1:0] sio_reg_out,
    output logic [2*SIO_PAIRS-1:0] sio_pull_allow,
    output logic [2*SIO_PAIRS*2-1:0] sio_thresh
);
    // the unit serves exactly one port of eight pins
    initial
    begin
        if (PINS != 8) $error("ppi_port_irq: PINS must be 8"); // [R2]
        if (SIO_PAIRS < 1 || SIO_PAIRS > 4) $error("ppi_port_irq: SIO_PAIRS 1..4");
    end

    localparam int SIO_PINS = 2 * SIO_PAIRS;

    logic [PINS-1:0] pin_sync;          // synchronised pin levels
    logic [PINS-1:0] pin_event;         // one-cycle edge events
    logic [PINS-1:0] status_reg;        // sticky events
    logic [PINS-1:0] mask_reg;          // interrupt enables, 1 passes
    logic [2*PINS-1:0] mode_reg;        // edge modes
    logic lvttl_reg;                    // port threshold select
    logic [PINS-1:0] dis_reg;           // input buffer disables
    logic [SIO_PINS-1:0] sio_reg_reg;   // regulated output select
    logic [2*SIO_PAIRS-1:0] sio_th_reg; // pair thresholds
    // data-phase capture
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic addr_take;
    logic rd_status;

    // pins pass two flops before edge logic
    ppi_sync #(.WIDTH(PINS)) u_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(pin_in),
        .q(pin_sync)
    );

    // edge detectors, gated only by mode
    ppi_edge #(.WIDTH(PINS)) u_edge
    (
        .clk(clk),
        .arst_n(arst_n),
        .level(pin_sync),
        .mode(mode_reg),
        .event_p(pin_event)
    );

    // address phase is taken when selected, active and bus ready
    assign addr_take = hsel && hready && (htrans == ppi_pkg::HTRANS_NONSEQ
                                          || htrans == ppi_pkg::HTRANS_SEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // latch the address phase for use in the data phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= '0;
        end
        else
        begin
            dp_valid_reg <= addr_take;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr;
        end
    end

    // read of status happens at the address phase so data is ready next cycle
    assign rd_status = addr_take && !hwrite && haddr == ppi_pkg::OFS_STATUS;

    // read data registered, valid in data phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata <= ppi_pkg::RESET_ZERO;
        else if (addr_take && !hwrite)
        begin
            hrdata <= ppi_pkg::RESET_ZERO;
            if (haddr == ppi_pkg::OFS_STATUS)
                hrdata[PINS-1:0] <= status_reg;  // [R11]
            else if (haddr == ppi_pkg::OFS_MASK)
                hrdata[PINS-1:0] <= mask_reg;
            else if (haddr == ppi_pkg::OFS_MODE)
                hrdata[2*PINS-1:0] <= mode_reg;
            else if (haddr == ppi_pkg::OFS_INCFG)
            begin
                hrdata[ppi_pkg::INCFG_LVTTL_BIT] <= lvttl_reg;
                hrdata[ppi_pkg::INCFG_DIS_LSB +: PINS] <= dis_reg;
            end
            else if (haddr == ppi_pkg::OFS_SIOCFG)
            begin
                hrdata[ppi_pkg::SIO_REG_LSB +: SIO_PINS] <= sio_reg_reg;
                hrdata[ppi_pkg::SIO_TH_LSB +: 2*SIO_PAIRS] <= sio_th_reg;
            end
            else if (haddr == ppi_pkg::OFS_PINS)
                hrdata[PINS-1:0] <= pin_sync;
            // unmapped addresses read zero
        end
    end

    // sticky status: new events win over a clearing read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status_reg <= '0;
        else if (rd_status)
            status_reg <= pin_event;                // [R11] [R4]
        else
            status_reg <= status_reg | pin_event;   // [R4] [R5]
    end

    // writable configuration, taken in the data phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_reg <= '0;
            mode_reg <= '0;
            lvttl_reg <= 1'b0;
            dis_reg <= '0;
            sio_reg_reg <= '0;
            sio_th_reg <= '0;
        end
        else if (dp_valid_reg && dp_write_reg)
        begin
            if (dp_addr_reg == ppi_pkg::OFS_MASK)
                mask_reg <= hwdata[PINS-1:0];
            else if (dp_addr_reg == ppi_pkg::OFS_MODE)
                mode_reg <= hwdata[2*PINS-1:0];                    // [R1] [R6]
            else if (dp_addr_reg == ppi_pkg::OFS_INCFG)
            begin
                lvttl_reg <= hwdata[ppi_pkg::INCFG_LVTTL_BIT];     // [R7]
                dis_reg <= hwdata[ppi_pkg::INCFG_DIS_LSB +: PINS]; // [R8]
            end
            else if (dp_addr_reg == ppi_pkg::OFS_SIOCFG)
            begin
                sio_reg_reg <= hwdata[ppi_pkg::SIO_REG_LSB +: SIO_PINS];   // [R9]
                sio_th_reg <= hwdata[ppi_pkg::SIO_TH_LSB +: 2*SIO_PAIRS];  // [R10]
            end
            // status, pins and unmapped addresses ignore writes
        end
    end

    // single level request, high while an unmasked status bit stands
    assign port_irq = |(status_reg & mask_reg);    // [R3] [R4] [R11]

    // configuration outputs straight from flops
    assign lvttl_sel = lvttl_reg;
    assign inbuf_dis = dis_reg;
    assign sio_reg_out = sio_reg_reg;

    // regulated pins lose resistive pulls; each pair shares one threshold
    genvar p;
    generate
        for (p = 0; p < SIO_PINS; p++)
        begin : g_sio
            assign sio_pull_allow[p] = ~sio_reg_reg[p];  // [R9]
            assign sio_thresh[2*p +: 2] = sio_th_reg[2*(p/2) +: 2]; // [R10]
        end
    endgenerate

    // a clearing read with no new event leaves status empty
    clear_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd_status && pin_event == '0 |=> status_reg == '0)
        else $error("status not cleared by read"); // [R11]

    // a rise in rise mode sets the status bit
    rise_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        pin_sync[0] && !$past(pin_sync[0]) && mode_reg[1:0] == 2'b01
        |=> status_reg[0])
        else $error("rise event lost"); // [R4]

    // no event in none mode
    none_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode_reg[1:0] == 2'b00 |-> !pin_event[0])
        else $error("event in none mode"); // [R1]

    // irq follows unmasked status
    irq_tie_a: assert property (@(posedge clk) disable iff (!arst_n)
        port_irq == |(status_reg & mask_reg))
        else $error("irq mismatch"); // [R3]

    // pulls never allowed on regulated pins
    sio_pull_a: assert property (@(posedge clk) disable iff (!arst_n)
        !(sio_pull_allow[0] && sio_reg_out[0]))
        else $error("pull on regulated pin"); // [R9]

    // pair members share threshold
    pair_th_a: assert property (@(posedge clk) disable iff (!arst_n)
        sio_thresh[1:0] == sio_thresh[3:2])
        else $error("pair threshold differs"); // [R10]

    // status bits hold without read
    status_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rd_status && status_reg[0] |=> status_reg[0])
        else $error("status dropped"); // [R5]

    // threshold write lands
    lvttl_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
        dp_valid_reg && dp_write_reg && dp_addr_reg == ppi_pkg::OFS_INCFG
        |=> lvttl_sel == $past(hwdata[0]))
        else $error("lvttl write lost"); // [R7]

    // buffer disable write lands one cycle after the data phase
    dis_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
        dp_valid_reg && dp_write_reg && dp_addr_reg == ppi_pkg::OFS_INCFG
        |=> inbuf_dis == $past(hwdata[ppi_pkg::INCFG_DIS_LSB +: PINS]))
        else $error("buffer disable write lost"); // [R8]

    // edge mode write lands for every pin at once
    mode_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
        dp_valid_reg && dp_write_reg && dp_addr_reg == ppi_pkg::OFS_MODE
        |=> mode_reg == $past(hwdata[2*PINS-1:0]))
        else $error("mode write lost"); // [R1]

    // regulated select write lands, pulls follow it
    sio_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
        dp_valid_reg && dp_write_reg && dp_addr_reg == ppi_pkg::OFS_SIOCFG
        |=> sio_reg_out == $past(hwdata[ppi_pkg::SIO_REG_LSB +: SIO_PINS]))
        else $error("regulated select write lost"); // [R9]

    // a fall in fall mode sets the status bit
    fall_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        !pin_sync[0] && $past(pin_sync[0]) && mode_reg[1:0] == 2'b10
        |=> status_reg[0])
        else $error("fall event lost"); // [R4]

    // a steady level never makes an event, there is no level mode
    level_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        pin_sync[0] == $past(pin_sync[0]) |-> !pin_event[0])
        else $error("event on steady level"); // [R6]

    // a clearing read with no new event drops the request
    irq_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd_status && pin_event == '0 |=> !port_irq)
        else $error("request not dropped after read"); // [R11]

    // a fully masked port never requests
    mask_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        mask_reg == '0 |-> !port_irq)
        else $error("request while masked"); // [R3]

    // any edge in both mode makes an event
    both_event_a: assert property (@(posedge clk) disable iff (!arst_n)
        pin_sync[0] != $past(pin_sync[0]) && mode_reg[1:0] == 2'b11
        |-> pin_event[0])
        else $error("both-edge event lost"); // [R1]

    // zero wait states and always okay on the bus
    bus_okay_a: assert property (@(posedge clk) disable iff (!arst_n)
        hreadyout && !hresp)
        else $error("bus not ready or error"); // [R3]
endmodule
`default_nettype wire

// ### test/ppi_far_model.sv
// Purpose: far side of the unit, port pins and interrupt controller
// Assumes: pins follow the bench command and hold for several clocks
// Notes: the controller side counts request rises
`timescale 1ns/1ps
`default_nettype none
module ppi_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // commanded and driven pin levels
    input wire logic [7:0] pin_cmd,
    output logic [7:0] pin_in,
    // interrupt line and rise count
    input wire logic port_irq,
    output logic [7:0] irq_seen
);
    logic irq_reg; // last request level
    // pins are plain push-pull levels, no release state to model
    assign pin_in = pin_cmd;
    // latch each new request, like a vector pending bit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_reg <= 1'b0;
            irq_seen <= 8'h00;
        end
        else
        begin
            irq_reg <= port_irq;
            if (port_irq && !irq_reg)
                irq_seen <= irq_seen + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### test/port_pin_interrupt_unit_tb.sv
// Purpose: self-checking bench for the port pin interrupt unit
// Assumes: zero wait state slave, bench is the only bus master
// Notes: edge rows in a table, awkward cases written out after
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module port_pin_interrupt_unit_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] pin_cmd = 8'h00;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, port_irq, lvttl_sel;
    wire logic [7:0] pin_in, inbuf_dis, irq_seen;
    wire logic [1:0] sio_reg_out, sio_pull_allow;
    wire logic [3:0] sio_thresh;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    // rows: mode, rising step, expected status bit; pin = row index
    logic [3:0] rows [8] = '{4'b0010, 4'b0000, 4'b0111, 4'b0100,
        4'b1010, 4'b1001, 4'b1111, 4'b1101};
    ppi_port_irq u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .port_irq(port_irq), .lvttl_sel(lvttl_sel),
        .inbuf_dis(inbuf_dis), .sio_reg_out(sio_reg_out),
        .sio_pull_allow(sio_pull_allow), .sio_thresh(sio_thresh));
    ppi_far_model u_far (.clk(clk), .arst_n(arst_n), .pin_cmd(pin_cmd),
        .pin_in(pin_in), .port_irq(port_irq), .irq_seen(irq_seen));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // one single transfer; the read word lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ppi_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a hang counts as a mismatch and ends the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        `CHK(port_irq, 1'b0)
        `CHK(lvttl_sel, 1'b0)
        `CHK(inbuf_dis, 8'h00)
        `CHK(hresp, 1'b0)
        `CHK(sio_pull_allow, 2'b11)
        $display("test reset done");
        bus(1'b1, ppi_pkg::OFS_MASK, 32'hff);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, ppi_pkg::OFS_MODE, 32'h0);
            pin_cmd[i] <= !rows[i][1];
            repeat (4) @(posedge clk);
            bus(1'b0, ppi_pkg::OFS_STATUS, 32'h0);
            bus(1'b1, ppi_pkg::OFS_MODE, 32'(rows[i][3:2]) << (2 * i));
            pin_cmd[i] <= rows[i][1];
            repeat (6) @(posedge clk);
            `CHK(port_irq, rows[i][0])
            bus(1'b0, ppi_pkg::OFS_STATUS, 32'h0);
            `CHK(rd, 32'(rows[i][0]) << i)
        end
        $display("test edge rows done");
        // a held high level must not keep setting status
        bus(1'b1, ppi_pkg::OFS_MODE, 32'h0);
        pin_cmd <= 8'h01;
        repeat (4) @(posedge clk);
        bus(1'b1, ppi_pkg::OFS_MODE, 32'h1);
        bus(1'b0, ppi_pkg::OFS_STATUS, 32'h0);
        repeat (8) @(posedge clk);
        bus(1'b0, ppi_pkg::OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        $display("test level done");
        // masked event stays in status, request follows the mask
        bus(1'b1, ppi_pkg::OFS_MASK, 32'h0);
        pin_cmd <= 8'h00;
        repeat (4) @(posedge clk);
        pin_cmd <= 8'h01;
        repeat (6) @(posedge clk);
        `CHK(port_irq, 1'b0)
        bus(1'b1, ppi_pkg::OFS_MASK, 32'h1);
        @(posedge clk);
        `CHK(port_irq, 1'b1)
        bus(1'b0, ppi_pkg::OFS_STATUS, 32'h0);
        `CHK(rd, 32'h1)
        @(posedge clk);
        `CHK(port_irq, 1'b0)
        `CHK(irq_seen, 8'd5)
        $display("test mask and clear done");
        bus(1'b0, ppi_pkg::OFS_PINS, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b0, 8'h1c, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, ppi_pkg::OFS_INCFG, 32'h0000_a501);
        @(posedge clk);
        `CHK(lvttl_sel, 1'b1)
        `CHK(inbuf_dis, 8'ha5)
        for (int t = 0; t < 4; t++)
        begin
            bus(1'b1, ppi_pkg::OFS_SIOCFG, 32'((t << 8) | t));
            @(posedge clk);
            `CHK(sio_thresh, {2'(t), 2'(t)})
            `CHK(sio_reg_out, 2'(t))
            `CHK(sio_pull_allow, ~2'(t))
        end
        $display("test config done");
        // reset in mid-run clears configuration again
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        `CHK(lvttl_sel, 1'b0)
        `CHK(sio_pull_allow, 2'b11)
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
